// File: rtl/motion_flags_pkg.sv
package motion_flags_pkg;

  // Register indices
  localparam logic [3:0] IDX_EVENT  = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_MASK0  = 4'ha;
  localparam logic [3:0] IDX_MASK1  = 4'hb;
  localparam logic [3:0] IDX_DETECT = 4'hc;

  // Event flag byte (index 0, read and clear share positions)
  localparam int BIT_Z_CHG     = 7;
  localparam int BIT_XY_CHG    = 6;
  localparam int BIT_SHAKE_LSB = 0;
  // Status byte (index 1 read)
  localparam int BIT_TILT      = 7;
  localparam int BIT_Z_SIGN    = 6;
  localparam int BIT_XY_LSB    = 4;
  localparam int BIT_READY     = 0;
  // Index 1 write
  localparam int BIT_SOFT_RST  = 4;
  localparam int BIT_READY_CLR = 0;
  // Detection register field
  localparam int BIT_ORC_LSB   = 0;

  // Reset values
  localparam logic [7:0] MASK0_RST  = 8'h00;
  localparam logic [7:0] MASK1_RST  = 8'h00;
  localparam logic [7:0] DETECT_RST = 8'h00;
  localparam logic [1:0] XY_RST     = 2'h0;
  localparam logic [1:0] Z_RST      = 2'h0;

  // XY orientation codes
  localparam logic [1:0] XY_POS_X = 2'h0;
  localparam logic [1:0] XY_POS_Y = 2'h1;
  localparam logic [1:0] XY_NEG_X = 2'h2;
  localparam logic [1:0] XY_NEG_Y = 2'h3;

  // Orientation threshold: 0.375 g at 1024 counts per g
  localparam int          ORIENT_THRESH_MILLI_G = 375;
  localparam int          ACC_COUNTS_PER_G      = 1024;
  localparam logic [11:0] ORIENT_THRESH_LSB     = 12'(ORIENT_THRESH_MILLI_G * ACC_COUNTS_PER_G / 1000);
  localparam logic [7:0]  ORC_BASE_COUNT        = 8'h10;

  // Bus address default
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h15;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'b0000001,
    ST_ADDR     = 7'b0000010,
    ST_ADDR_ACK = 7'b0000100,
    ST_WR       = 7'b0001000,
    ST_WR_ACK   = 7'b0010000,
    ST_RD       = 7'b0100000,
    ST_RD_ACK   = 7'b1000000
  } bus_state_t;

endpackage

// File: rtl/orient_debounce.sv
`timescale 1ns/1ps
module orient_debounce
  import motion_flags_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Candidate reading
  input  wire logic       tick,
  input  wire logic       valid,
  input  wire logic [1:0] cand,
  input  wire logic [7:0] need,
  input  wire logic [1:0] rst_code,
  // Filtered code
  output logic [1:0]      code_q,
  output logic            changed_q
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [1:0] last_q;
  logic [1:0] last_d;
  logic [1:0] code_d;
  logic       changed_d;

  always_comb begin
    cnt_d     = cnt_q;
    last_d    = last_q;
    code_d    = code_q;
    changed_d = 1'b0;
    if (tick) begin
      if (valid && cand != code_q) begin
        if (cand == last_q && cnt_q != 8'h00) begin
          if (cnt_q + 8'h01 >= need) begin  // [R21]
            code_d    = cand;
            changed_d = 1'b1;
            cnt_d     = 8'h00;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end else begin
          last_d = cand;
          cnt_d  = 8'h01;
        end
      end else begin
        cnt_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q     <= 8'h00;
      last_q    <= 2'h0;
      code_q    <= rst_code;
      changed_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      last_q    <= last_d;
      code_q    <= code_d;
      changed_q <= changed_d;
    end
  end

endmodule

// File: rtl/motion_event_flags_i2c_regs.sv
`timescale 1ns/1ps
// Functional notes
// (R1) First written byte loads register pointer
// (R2) Later written bytes store, pointer increments
// (R3) Master reads after pointer write, repeated start
// (R4) Read returns pointed register, pointer increments
// (R5) Master keeps SCL and SDA low briefly
// (R6) Sixteen eight-bit registers, indices 0 to 15
// (R7) Index 0 reads change and shake flags
// (R8) Index 0 write clears matching flags
// (R9) Index 1 reads tilt, orientation, data ready
// (R10) Index 1 write: soft reset, ready clear
// (R11) Reads hit flags, writes hit clears only
// (R12) Events set flags, held until cleared
// (R13) Writing one clears flag, clear self-returns
// (R14) Zero clear bits leave flags alone
// (R15) Shake detection sets per-direction flags
// (R16) Set shake flag blocks that axis
// (R17) Debounced orientation change sets change flags
// (R18) XY code: +X, +Y, -X, -Y
// (R19) XY updates only above threshold, untilted
// (R20) Z code: tilt bit and Z sign
// (R21) New orientation needs consecutive valid readings
// (R22) New measurement sets data ready flag
// (R23) Count field selects 16, 32, 64, 128
// (R24) Masked flags drive active-low interrupt
// (R25) Soft reset lasts the transfer, spares bus
// (R26) Pointer wraps from fifteen to zero
module motion_event_flags_i2c_regs
  import motion_flags_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Two-wire bus
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  // Interrupt pin, open drain
  output logic             INT_OUT,
  output logic             INT_OE_N,
  // Measurement side
  input  wire logic        SAMPLE_TICK,
  input  wire logic [11:0] X_ACC,
  input  wire logic [11:0] Y_ACC,
  input  wire logic [11:0] Z_ACC,
  input  wire logic [3:0]  SHAKE_DET,
  // Registers held elsewhere
  output logic [3:0]       REG_PTR,
  input  wire logic [7:0]  REG_RDATA,
  output logic             REG_WR,
  output logic [3:0]       REG_IDX,
  output logic [7:0]       REG_WDATA,
  output logic             SOFT_RESET
);

  function automatic logic [11:0] mag12(input logic [11:0] v);
    mag12 = v[11] ? 12'(-v) : v;
  endfunction

  function automatic logic [7:0] orc_need(input logic [1:0] orient_debounce_count);
    orc_need = ORC_BASE_COUNT << orient_debounce_count;  // [R23]
  endfunction

  // Pin synchronisers
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sda_s;

  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], SCL_IN};
      sda_q <= {sda_q[1:0], SDA_IN};
    end
  end

  assign sda_s     = sda_q[1];
  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
  assign stop_det  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

  // Bus slave state
  bus_state_t st_q;
  bus_state_t st_d;
  logic [3:0] bitcnt_q;
  logic [3:0] bitcnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [3:0] ptr_q;
  logic [3:0] ptr_d;
  logic       first_q;
  logic       first_d;
  logic       rw_q;
  logic       rw_d;
  logic       ack_q;
  logic       ack_d;
  logic       sda_low_q;
  logic       sda_low_d;
  logic       wr_stb_q;
  logic       wr_stb_d;
  logic [3:0] wr_idx_q;
  logic [3:0] wr_idx_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;
  logic       srst_q;
  logic       srst_d;
  logic [7:0] rd_byte;

  always_comb begin
    st_d      = st_q;
    bitcnt_d  = bitcnt_q;
    sh_d      = sh_q;
    ptr_d     = ptr_q;
    first_d   = first_q;
    rw_d      = rw_q;
    ack_d     = ack_q;
    sda_low_d = sda_low_q;
    wr_stb_d  = 1'b0;
    wr_idx_d  = wr_idx_q;
    wr_data_d = wr_data_q;
    srst_d    = srst_q;
    if (start_det) begin
      st_d      = ST_ADDR;
      bitcnt_d  = 4'h0;
      sda_low_d = 1'b0;
    end else if (stop_det) begin
      st_d      = ST_IDLE;
      sda_low_d = 1'b0;
      srst_d    = 1'b0;  // [R25]
    end else begin
      case (st_q)
        ST_IDLE: begin
          sda_low_d = 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            sh_d     = {sh_q[6:0], sda_s};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              rw_d      = sh_q[0];
              sda_low_d = 1'b1;
              st_d      = ST_ADDR_ACK;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bitcnt_d = 4'h0;
            if (rw_q) begin
              sh_d      = rd_byte;  // [R4]
              sda_low_d = ~rd_byte[7];
              st_d      = ST_RD;
            end else begin
              sda_low_d = 1'b0;
              first_d   = 1'b1;
              st_d      = ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_rise) begin
            sh_d     = {sh_q[6:0], sda_s};
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == 4'h8) begin
            sda_low_d = 1'b1;
            st_d      = ST_WR_ACK;
            if (first_q) begin
              ptr_d   = sh_q[3:0];  // [R1] [R26]
              first_d = 1'b0;
            end else begin
              wr_stb_d  = 1'b1;  // [R2]
              wr_idx_d  = ptr_q;
              wr_data_d = sh_q;
              ptr_d     = ptr_q + 4'h1;  // [R2] [R26]
              if (ptr_q == IDX_STATUS && sh_q[BIT_SOFT_RST]) begin
                srst_d = 1'b1;  // [R10] [R25]
              end
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            sda_low_d = 1'b0;
            bitcnt_d  = 4'h0;
            st_d      = ST_WR;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bitcnt_d = bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == 4'h8) begin
              sda_low_d = 1'b0;
              ptr_d     = ptr_q + 4'h1;  // [R4] [R26]
              st_d      = ST_RD_ACK;
            end else begin
              sh_d      = {sh_q[6:0], 1'b0};
              sda_low_d = ~sh_q[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            ack_d = ~sda_s;
          end else if (scl_fall) begin
            bitcnt_d = 4'h0;
            if (ack_q) begin
              sh_d      = rd_byte;  // [R4]
              sda_low_d = ~rd_byte[7];
              st_d      = ST_RD;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          st_d      = ST_IDLE;
          sda_low_d = 1'b0;
        end
      endcase
    end
  end

  // Bus logic stays on the pin reset only, so a soft reset is still acknowledged
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q      <= ST_IDLE;
      bitcnt_q  <= 4'h0;
      sh_q      <= 8'h00;
      ptr_q     <= 4'h0;
      first_q   <= 1'b0;
      rw_q      <= 1'b0;
      ack_q     <= 1'b0;
      sda_low_q <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_idx_q  <= 4'h0;
      wr_data_q <= 8'h00;
      srst_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      bitcnt_q  <= bitcnt_d;
      sh_q      <= sh_d;
      ptr_q     <= ptr_d;
      first_q   <= first_d;
      rw_q      <= rw_d;
      ack_q     <= ack_d;
      sda_low_q <= sda_low_d;
      wr_stb_q  <= wr_stb_d;
      wr_idx_q  <= wr_idx_d;
      wr_data_q <= wr_data_d;
      srst_q    <= srst_d;
    end
  end

  // Event and orientation state
  logic       core_rst;
  logic [3:0] shake_q;
  logic [3:0] shake_d;
  logic       xy_orient_change_flag_q;
  logic       xy_orient_change_flag_d;
  logic       z_orient_change_flag_q;
  logic       z_orient_change_flag_d;
  logic       sample_ready_flag_q;
  logic       sample_ready_flag_d;
  logic [7:0] mask0_q;
  logic [7:0] mask0_d;
  logic [7:0] mask1_q;
  logic [7:0] mask1_d;
  logic [7:0] detect_q;
  logic [7:0] detect_d;
  logic       int_act_q;
  logic       int_act_d;
  logic [7:0] clr0;
  logic [7:0] clr1;
  logic [7:0] event_flag_byte;
  logic [7:0] status_byte;
  logic [11:0] ax;
  logic [11:0] ay;
  logic        tilt_now;
  logic [1:0]  xy_cand;
  logic [1:0]  z_cand;
  logic [1:0]  xy_orient_code;
  logic [1:0]  z_orient_code;
  logic        xy_changed;
  logic        z_changed;
  logic [7:0]  need;

  assign core_rst = RST | srst_q;  // [R25]
  assign need     = orc_need(detect_q[BIT_ORC_LSB +: 2]);

  // Orientation candidates from the current sample
  always_comb begin
    ax       = mag12(X_ACC);
    ay       = mag12(Y_ACC);
    tilt_now = ((ax > ay) ? ax : ay) <= ORIENT_THRESH_LSB;  // [R19] [R20]
    if (ax >= ay) begin
      xy_cand = X_ACC[11] ? XY_NEG_X : XY_POS_X;  // [R18]
    end else begin
      xy_cand = Y_ACC[11] ? XY_NEG_Y : XY_POS_Y;  // [R18]
    end
    z_cand = {tilt_now, Z_ACC[11]};  // [R20]
  end

  orient_debounce u_xy_filter (
    .clk       (CLK),
    .rst       (core_rst),
    .tick      (SAMPLE_TICK),
    .valid     (~tilt_now),  // [R19]
    .cand      (xy_cand),
    .need      (need),
    .rst_code  (XY_RST),
    .code_q    (xy_orient_code),
    .changed_q (xy_changed)
  );

  orient_debounce u_z_filter (
    .clk       (CLK),
    .rst       (core_rst),
    .tick      (SAMPLE_TICK),
    .valid     (1'b1),
    .cand      (z_cand),
    .need      (need),
    .rst_code  (Z_RST),
    .code_q    (z_orient_code),
    .changed_q (z_changed)
  );

  assign event_flag_byte = {z_orient_change_flag_q, xy_orient_change_flag_q, 2'b00, shake_q};  // [R7]
  assign status_byte     = {z_orient_code, xy_orient_code, 3'b000, sample_ready_flag_q};  // [R9]

  // Read side sees flags only; clears are write-only pulses
  always_comb begin
    case (ptr_q)
      IDX_EVENT:  rd_byte = event_flag_byte;  // [R11]
      IDX_STATUS: rd_byte = status_byte;  // [R11]
      IDX_MASK0:  rd_byte = 8'h00;
      IDX_MASK1:  rd_byte = 8'h00;
      IDX_DETECT: rd_byte = detect_q;
      default:    rd_byte = REG_RDATA;  // [R6]
    endcase
  end

  always_comb begin
    clr0 = (wr_stb_q && wr_idx_q == IDX_EVENT) ? wr_data_q : 8'h00;  // [R8] [R13] [R14]
    clr1 = (wr_stb_q && wr_idx_q == IDX_STATUS) ? wr_data_q : 8'h00;  // [R10] [R13]
    // Set wins over a clear in the same cycle, except for a shake flag whose pair is already set
    shake_d = (shake_q & ~clr0[BIT_SHAKE_LSB +: 4])
            | (SHAKE_DET & {{2{~|shake_q[3:2]}}, {2{~|shake_q[1:0]}}});  // [R12] [R15] [R16]
    xy_orient_change_flag_d = (xy_orient_change_flag_q & ~clr0[BIT_XY_CHG]) | xy_changed;  // [R17]
    z_orient_change_flag_d  = (z_orient_change_flag_q & ~clr0[BIT_Z_CHG]) | z_changed;  // [R17]
    sample_ready_flag_d     = (sample_ready_flag_q & ~clr1[BIT_READY_CLR]) | SAMPLE_TICK;  // [R22]
    mask0_d  = (wr_stb_q && wr_idx_q == IDX_MASK0) ? wr_data_q : mask0_q;
    mask1_d  = (wr_stb_q && wr_idx_q == IDX_MASK1) ? wr_data_q : mask1_q;
    detect_d = (wr_stb_q && wr_idx_q == IDX_DETECT) ? wr_data_q : detect_q;
    int_act_d = |(event_flag_byte & mask0_q) | |(status_byte[2:0] & mask1_q[2:0]);  // [R24]
  end

  always_ff @(posedge CLK) begin
    if (core_rst) begin
      shake_q                 <= 4'h0;
      xy_orient_change_flag_q <= 1'b0;
      z_orient_change_flag_q  <= 1'b0;
      sample_ready_flag_q     <= 1'b0;
      mask0_q                 <= MASK0_RST;
      mask1_q                 <= MASK1_RST;
      detect_q                <= DETECT_RST;
      int_act_q               <= 1'b0;
    end else begin
      shake_q                 <= shake_d;
      xy_orient_change_flag_q <= xy_orient_change_flag_d;
      z_orient_change_flag_q  <= z_orient_change_flag_d;
      sample_ready_flag_q     <= sample_ready_flag_d;
      mask0_q                 <= mask0_d;
      mask1_q                 <= mask1_d;
      detect_q                <= detect_d;
      int_act_q               <= int_act_d;
    end
  end

  assign SDA_OUT    = 1'b0;
  assign SDA_OE_N   = ~sda_low_q;
  assign INT_OUT    = 1'b0;
  assign INT_OE_N   = ~int_act_q;  // [R24]
  assign REG_PTR    = ptr_q;
  assign REG_WR     = wr_stb_q;
  assign REG_IDX    = wr_idx_q;
  assign REG_WDATA  = wr_data_q;
  assign SOFT_RESET = srst_q;

endmodule

// File: sim/motion_flags_checker.sv
`timescale 1ns/1ps
module motion_flags_checker
  import motion_flags_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Bus pins
  input  wire logic       SCL_IN,
  input  wire logic       SDA_OE_N,
  input  wire logic       INT_OE_N,
  // Register side
  input  wire logic [3:0] REG_PTR,
  input  wire logic       REG_WR,
  input  wire logic [3:0] REG_IDX,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       SOFT_RESET
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  logic soft_cmd;
  assign soft_cmd = REG_WR && REG_IDX == IDX_STATUS && REG_WDATA[BIT_SOFT_RST];

  wr_pulse_a: assert property (REG_WR |=> !REG_WR)
    else $error("write strobe too long");
  ptr_step_a: assert property (REG_WR |-> ##[0:2] REG_PTR == 4'(REG_IDX + 4'h1))
    else $error("pointer did not step");
  data_ack_a: assert property (REG_WR |-> ##[0:1] !SDA_OE_N)
    else $error("written byte not acknowledged");
  soft_set_a: assert property (soft_cmd |=> SOFT_RESET)
    else $error("soft reset not started");
  soft_quiet_a: assert property ($rose(SOFT_RESET) |-> soft_cmd)
    else $error("soft reset without command");
  soft_hold_a: assert property ($rose(SOFT_RESET) |-> SOFT_RESET [*8])
    else $error("soft reset ended early");
  int_drop_a: assert property (SOFT_RESET |-> ##[0:2] INT_OE_N)
    else $error("interrupt held in soft reset");
  sda_steady_a: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_N))
    else $error("data changed while clock high");
  reset_idle_a: assert property ($past(RST) |-> SDA_OE_N && INT_OE_N && !REG_WR && !SOFT_RESET)
    else $error("outputs not idle after reset");

  cover property (REG_WR && REG_IDX == 4'hf);
  cover property ($rose(SOFT_RESET));
  cover property ($fell(INT_OE_N));
endmodule

bind motion_event_flags_i2c_regs motion_flags_checker chk_u (
  .CLK(CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OE_N(SDA_OE_N), .INT_OE_N(INT_OE_N), .REG_PTR(REG_PTR),
  .REG_WR(REG_WR), .REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .SOFT_RESET(SOFT_RESET)
);

// File: sim/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  // Clock and resolved data line
  input  wire logic clk,
  input  wire logic sda,
  // Bus lines, a released data line reads high
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task q;
    repeat (2) @(posedge clk);
  endtask

  // 320 ns per bit: data set early in the low phase, sampled at the end of high
  task bit_x(input logic b, output logic r);
    q;
    sda_low <= ~b;
    q;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    scl <= 1'b0;
  endtask

  // Also a repeated start; waits out an acknowledge still held low
  task start;
    q;
    sda_low <= 1'b0;
    repeat (2) q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
  endtask

  task stop;
    q;
    sda_low <= 1'b1;
    repeat (2) q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask

  // Eight bits out, then the ninth bit a; ack is the ninth bit seen low
  task xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], s);
      r[i] = s;
    end
    bit_x(a, s);
    ack = ~s;
  endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb
  import motion_flags_pkg::*;
;
  localparam logic [6:0] ADDR = DEV_ADDR_DEFAULT;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        tick = 1'b0;
  logic [11:0] x = 12'h000;
  logic [11:0] y = 12'h000;
  logic [11:0] z = 12'h000;
  logic [3:0]  shk = 4'h0;
  logic [7:0]  rdata = 8'h00;
  logic        saw = 1'b0;
  logic [3:0]  ptr, idx;
  logic [7:0]  wdata, v;
  logic        scl, sda_low, sda, oe_n, int_n, wr, srst, a;
  logic [11:0] wq[$];
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  assign sda = ~(sda_low | ~oe_n);
  always #20 clk = ~clk;

  motion_event_flags_i2c_regs #(.DEV_ADDR(ADDR)) dut_u (
    .CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE_N(oe_n), .INT_OUT(),
    .INT_OE_N(int_n), .SAMPLE_TICK(tick), .X_ACC(x), .Y_ACC(y), .Z_ACC(z), .SHAKE_DET(shk),
    .REG_PTR(ptr), .REG_RDATA(rdata), .REG_WR(wr), .REG_IDX(idx), .REG_WDATA(wdata), .SOFT_RESET(srst)
  );
  i2c_master_model m_u (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

  // Outside registers, write log, timeout
  always @(posedge clk) begin
    rdata <= {4'h5, ptr};
    if (srst === 1'b1) saw <= 1'b1;
    if (wr === 1'b1) wq.push_back({idx, wdata});
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      close_out;
    end
  end

  task close_out;
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task sb(input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    m_u.xfer(d, 1'b1, r, k);
    chk({11'h0, k}, 12'h001);
  endtask

  task wr_reg(input logic [3:0] p, input logic [7:0] d);
    m_u.start;
    sb({ADDR, 1'b0});
    sb({4'h0, p});
    sb(d);
    m_u.stop;
  endtask

  task rd_reg(input logic [3:0] p, input logic [7:0] e);
    logic [7:0] r;
    logic       k;
    m_u.start;
    sb({ADDR, 1'b0});
    sb({4'h0, p});
    m_u.start;
    sb({ADDR, 1'b1});
    m_u.xfer(8'hff, 1'b1, r, k);
    m_u.stop;
    chk({4'h0, r}, {4'h0, e});
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
    end
  endtask

  task pulse(input logic [3:0] b);
    @(posedge clk) shk <= b;
    @(posedge clk) shk <= 4'h0;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_reg(IDX_EVENT, 8'h00);
    rd_reg(IDX_STATUS, 8'h00);
    pulse(4'h1);
    pulse(4'h2);
    pulse(4'h4);
    rd_reg(IDX_EVENT, 8'h05);
    wr_reg(IDX_EVENT, 8'h30);
    rd_reg(IDX_EVENT, 8'h05);
    wr_reg(IDX_EVENT, 8'h01);
    pulse(4'h2);
    pulse(4'h8);
    rd_reg(IDX_EVENT, 8'h06);
    wr_reg(IDX_MASK0, 8'h02);
    chk({11'h0, int_n}, 12'h000);
    wr_reg(IDX_EVENT, 8'h02);
    chk({11'h0, int_n}, 12'h001);
    ticks(1);
    rd_reg(IDX_STATUS, 8'h01);
    wr_reg(IDX_STATUS, 8'h01);
    rd_reg(IDX_STATUS, 8'h00);
    x <= 12'hc00;
    ticks(16);
    rd_reg(IDX_STATUS, {2'b00, XY_NEG_X, 4'h1});
    rd_reg(IDX_EVENT, 8'h44);
    wr_reg(IDX_EVENT, 8'hff);
    wr_reg(IDX_DETECT, 8'h01);
    x <= 12'h000;
    y <= 12'h180;
    z <= 12'hc00;
    ticks(31);
    rd_reg(IDX_STATUS, {2'b00, XY_NEG_X, 4'h1});
    ticks(1);
    rd_reg(IDX_STATUS, {2'b11, XY_NEG_X, 4'h1});
    rd_reg(IDX_EVENT, 8'h80);
    wq.delete();
    m_u.start;
    sb({ADDR, 1'b0});
    sb(8'h0f);
    sb(8'h3c);
    sb(8'hff);
    m_u.stop;
    chk(wq[0], 12'hf3c);
    chk(wq[1], 12'h0ff);
    m_u.start;
    sb({ADDR, 1'b0});
    sb(8'h0e);
    m_u.start;
    sb({ADDR, 1'b1});
    m_u.xfer(8'hff, 1'b0, v, a);
    chk({4'h0, v}, 12'h05e);
    m_u.xfer(8'hff, 1'b0, v, a);
    chk({4'h0, v}, 12'h05f);
    m_u.xfer(8'hff, 1'b1, v, a);
    chk({4'h0, v}, 12'h000);
    m_u.stop;
    m_u.start;
    m_u.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, v, a);
    chk({11'h0, a}, 12'h000);
    m_u.stop;
    pulse(4'h1);
    wr_reg(IDX_STATUS, 8'h10);
    chk({11'h0, saw}, 12'h001);
    rd_reg(IDX_EVENT, 8'h00);
    rd_reg(IDX_STATUS, 8'h00);
    wr_reg(IDX_DETECT, 8'h03);
    y <= 12'h400;
    z <= 12'h000;
    ticks(127);
    rd_reg(IDX_STATUS, 8'h01);
    ticks(1);
    rd_reg(IDX_STATUS, {2'b00, XY_POS_Y, 4'h1});
    close_out;
  end
endmodule
